// >>> include/pao_pkg.sv
// Package for the pipelined converter output timing block
//
// Functional notes
// - Results leave as two's complement words
// - Range flag high at either full-scale code
// - Conversion starts on a sample clock rise while idle with a code queued
// - A started conversion always runs to completion
// - Output updates at end of conversion time
// - Two further started conversions of pipeline latency
// - Refresh timer runs after 1 ms idle clock
package pao_pkg;

   localparam int          DATA_W        = 14;
   localparam int          PIPE_STAGES   = 2;
   localparam int          CLK_PERIOD_PS = 4000;
   localparam int          CONV_TIME_NS  = 100;
   // Least time, rounded up to whole cycles
   localparam int          CONV_CYCLES   =
      (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          IDLE_TIME_US  = 1000;
   localparam int          IDLE_CYCLES   =
      (IDLE_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int          FIFO_DEPTH    = 16;
   localparam logic [13:0] CODE_NEG_FS   = 14'h2000;
   localparam logic [13:0] CODE_POS_FS   = 14'h1fff;
   localparam logic [13:0] DATA_RST      = 14'h0000;

   typedef struct packed {
      logic                  out_of_range_flag;
      logic [DATA_W-1:0]     word;
   } pao_sample_t;

   typedef enum logic [1:0] {
      PAO_IDLE,
      PAO_CONVERT
   } pao_state_t;

endpackage : pao_pkg

// >>> design/pao_top.sv
// Converter output timing: sample FIFO, conversion timer, pipeline
`timescale 1ns/1ps

// ***********************************************************
// Sample FIFO
// ***********************************************************
module pao_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             push;
   logic             pop;

   // ***********************************************************
   // Parameter checks
   // ***********************************************************
   // Pointers wrap by overflow, so only powers of two are served
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("pao_fifo: DEPTH must be a power of two");
      if (WIDTH < 1)
         $error("pao_fifo: WIDTH must be at least one");
   end

   // ***********************************************************
   // Handshake
   // ***********************************************************
   assign out_valid = cnt_q != '0;
   assign out_data  = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   // Ready is a flop so the top port has no logic behind it
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         in_ready <= 1'b1;
      else
         in_ready <= cnt_d != (AW+1)'(DEPTH);
   end

   // ***********************************************************
   // Storage
   // ***********************************************************
   // No reset on the array: contents are only read when counted
   always_ff @(posedge clk) begin
      if (push)
         mem[wr_q] <= in_data;
   end

   // ***********************************************************
   // Pointers and fill count
   // ***********************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule : pao_fifo

// ***********************************************************
// Converter output timing top
// ***********************************************************
module pao_top
   import pao_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES,
   parameter int IDLE_CYC = IDLE_CYCLES,
   parameter int DEPTH    = FIFO_DEPTH
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              sample_clk,
   input  wire logic [DATA_W-1:0] core_code,
   input  wire logic              core_valid,
   output logic                   core_ready,
   output logic      [DATA_W-1:0] data_out,
   output logic                   out_of_range_flag,
   output logic                   refresh_active,
   output logic                   busy
);
   localparam int CW = $clog2(CONV_CYC + 1);
   localparam int IW = $clog2(IDLE_CYC + 1);

   pao_sample_t   fifo_out;
   logic          fifo_valid;
   logic          fifo_pop;
   logic          samp_q;
   logic          rise;
   pao_state_t    state_q;
   logic [CW-1:0] conv_cnt_q;
   logic [IW-1:0] idle_cnt_q;
   pao_sample_t   conv_q;
   pao_sample_t   pipe_q [PIPE_STAGES];
   logic          ovr_in;
   logic          end_conv;

   // ***********************************************************
   // Parameter checks
   // ***********************************************************
   initial begin
      if (CONV_CYC < 1 || IDLE_CYC < 1)
         $error("pao_top: counts must be at least one");
      if (PIPE_STAGES < 1)
         $error("pao_top: pipeline needs at least one place");
      if (DEPTH < 2)
         $error("pao_top: FIFO needs at least two words");
   end

   // ***********************************************************
   // Range detection and input FIFO
   // ***********************************************************

   // Full-scale detection used on every sample
   function automatic logic is_full_scale(logic [DATA_W-1:0] c);
      return (c == CODE_NEG_FS) || (c == CODE_POS_FS);
   endfunction : is_full_scale

   assign ovr_in = is_full_scale(fifo_out.word);

   pao_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (core_valid),
      .in_ready  (core_ready),
      .in_data   ({1'b0, core_code}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out)
   );

   // ***********************************************************
   // Start edge detection
   // ***********************************************************
   // Only rising edges count; fall ignored, any duty cycle
   assign rise     = sample_clk && !samp_q;
   // Pop a code on each start edge; no code means sample stalls
   assign fifo_pop = rise && (state_q == PAO_IDLE) && fifo_valid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         samp_q <= 1'b0;
      else
         samp_q <= sample_clk;
   end

   // ***********************************************************
   // Conversion timer
   // ***********************************************************
   assign end_conv = (state_q == PAO_CONVERT) && (conv_cnt_q == '0);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q    <= PAO_IDLE;
         conv_cnt_q <= '0;
         conv_q     <= '0;
      end else begin
         unique case (state_q)
            PAO_IDLE: begin
               if (fifo_pop) begin
                  state_q    <= PAO_CONVERT;
                  conv_cnt_q <= CW'(CONV_CYC - 1);
                  conv_q     <= '{ovr_in, fifo_out.word};
               end
            end
            PAO_CONVERT: begin
               // Edges during conversion neither abort nor restart
               if (conv_cnt_q == '0) begin
                  state_q <= PAO_IDLE;
               end else begin
                  conv_cnt_q <= conv_cnt_q - 1'b1;
               end
            end
            default: state_q <= PAO_IDLE;
         endcase
      end
   end

   // Busy pin follows the converting state from its own flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         busy <= 1'b0;
      else if (fifo_pop)
         busy <= 1'b1;
      else if (end_conv)
         busy <= 1'b0;
   end

   // ***********************************************************
   // Pipeline
   // ***********************************************************
   // Each start edge shifts results one place: two-edge latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pipe_q[0] <= '0;
      else if (fifo_pop)
         pipe_q[0] <= conv_q;
   end

   for (genvar g = 1; g < PIPE_STAGES; g++) begin : g_pipe
      always_ff @(posedge clk or posedge rst) begin
         if (rst)
            pipe_q[g] <= '0;
         else if (fifo_pop)
            pipe_q[g] <= pipe_q[g-1];
      end
   end

   // ***********************************************************
   // Output bus
   // ***********************************************************
   // Bus updates only at end of conversion, word and flag together
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_out          <= DATA_RST;
         out_of_range_flag <= 1'b0;
      end else if (end_conv) begin
         data_out          <= pipe_q[PIPE_STAGES-1].word;
         out_of_range_flag <= pipe_q[PIPE_STAGES-1].out_of_range_flag;
      end
   end

   // ***********************************************************
   // Idle refresh timer
   // ***********************************************************
   // Counter parks at its limit so it cannot wrap while idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         idle_cnt_q <= '0;
      else if (rise)
         idle_cnt_q <= '0;
      else if (idle_cnt_q != IW'(IDLE_CYC - 1))
         idle_cnt_q <= idle_cnt_q + 1'b1;
   end

   // Refresh stays on until the next start edge, even if stalled
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         refresh_active <= 1'b0;
      else if (rise)
         refresh_active <= 1'b0;
      else if (idle_cnt_q == IW'(IDLE_CYC - 1))
         refresh_active <= 1'b1;
   end
endmodule : pao_top

// >>> tb/pao_top_sva.sv
// Checker for converter output timing
`timescale 1ns/1ps
module pao_top_sva
   import pao_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES,
   parameter int IDLE_CYC = IDLE_CYCLES
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              sample_clk,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              out_of_range_flag,
   input wire logic              refresh_active,
   input wire logic              busy
);
   // ***
   // Helper counts
   // ***
   int   busy_n_q;
   int   idle_n_q;
   logic sclk_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) busy_n_q <= 0;
      else busy_n_q <= busy ? busy_n_q + 1 : 0;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) sclk_q <= 1'b0;
      else sclk_q <= sample_clk;
   end
   // Slack of three for the sync stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) idle_n_q <= 0;
      else idle_n_q <= (sample_clk && !sclk_q) ? 0 : idle_n_q + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rise; $rose(sample_clk); endsequence
   sequence s_conv; busy [*8]; endsequence
   AST_START: assert property ($rose(busy) |-> $past(sample_clk)
      && !$past(sample_clk, 2)) else $error("busy without rise");
   AST_FALL: assert property ($fell(sample_clk) && !busy |=> !busy)
      else $error("falling edge started");
   AST_HOLD: assert property ($rose(busy) |-> s_conv)
      else $error("conversion cut short");
   AST_LEN: assert property ($fell(busy) |-> busy_n_q == CONV_CYC)
      else $error("conversion length");
   AST_FLAG: assert property (out_of_range_flag ==
      (data_out == CODE_NEG_FS || data_out == CODE_POS_FS))
      else $error("range flag wrong");
   AST_TOGETHER: assert property (
      !$stable({out_of_range_flag, data_out}) |-> $past(busy))
      else $error("output changed outside update");
   AST_IDLE: assert property ($rose(refresh_active) |->
      idle_n_q >= IDLE_CYC - 3 && idle_n_q <= IDLE_CYC + 3)
      else $error("refresh timing");
   AST_WAKE: assert property ((s_rise and refresh_active) |->
      ##[1:3] !refresh_active) else $error("refresh not cleared");
endmodule : pao_top_sva

bind pao_top pao_top_sva #(.CONV_CYC(CONV_CYC), .IDLE_CYC(IDLE_CYC)) sva_u (
   .clk(clk), .rst(rst), .sample_clk(sample_clk), .data_out(data_out),
   .out_of_range_flag(out_of_range_flag),
   .refresh_active(refresh_active), .busy(busy));

// >>> tb/pao_cap.sv
// Capture logic model: makes sample clock, latches result words
`timescale 1ns/1ps
module pao_cap
   import pao_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              go,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              out_of_range_flag,
   output logic                  sample_clk,
   output pao_sample_t           cap
);
   // ***
   // Clock pulse and capture
   // ***
   logic [1:0] hi_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) hi_q <= 2'h0;
      else if (go) hi_q <= 2'h3;
      else if (hi_q != 2'h0) hi_q <= hi_q - 2'h1;
   end
   // Short high phase, long low phase
   assign sample_clk = !rst && (hi_q != 2'h0);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cap <= '0;
      else if (go) cap <= {out_of_range_flag, data_out};
   end
endmodule : pao_cap

// >>> tb/testbench.sv
// Self-checking testbench for converter output timing
`timescale 1ns/1ps
module testbench;
   import pao_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              go = 1'b0;
   logic              core_valid = 1'b0;
   logic [DATA_W-1:0] core_code = 14'h0000;
   logic [DATA_W-1:0] data_out;
   logic              core_ready, out_of_range_flag, refresh_active;
   logic              busy, sample_clk;
   pao_sample_t       cap;
   logic [DATA_W-1:0] sent[$];
   logic [DATA_W-1:0] q[$];
   int                n_fail = 0;
   int                n_checks = 0;
   int                nst = 0;
   pao_top #(.IDLE_CYC(50)) dut_u (.clk(clk), .rst(rst),
      .sample_clk(sample_clk), .core_code(core_code),
      .core_valid(core_valid), .core_ready(core_ready),
      .data_out(data_out), .out_of_range_flag(out_of_range_flag),
      .refresh_active(refresh_active), .busy(busy));
   pao_cap cap_u (.clk(clk), .rst(rst), .go(go), .data_out(data_out),
      .out_of_range_flag(out_of_range_flag), .sample_clk(sample_clk),
      .cap(cap));
   // ***
   // Tasks
   // ***
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic push();
      foreach (q[i]) begin
         core_code  <= q[i];
         core_valid <= 1'b1;
         @(negedge clk);
         while (core_ready !== 1'b1) @(negedge clk);
         @(posedge clk);
         sent.push_back(q[i]);
      end
      core_valid <= 1'b0;
   endtask : push
   task automatic pulse();
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask : pulse
   // Extra rise lands mid-conversion and must be ignored
   task automatic start(input bit extra);
      logic [DATA_W-1:0] w;
      pulse();
      if (extra) begin
         repeat (8) @(posedge clk);
         pulse();
      end
      repeat (20) @(posedge clk);
      w = (nst < 3) ? DATA_RST : sent[nst-3];
      chk(cap.word === w, "word");
      chk({~cap.word[13], cap.word[12:0]} === (w ^ 14'h2000), "offset");
      chk(cap.out_of_range_flag === (w == CODE_NEG_FS || w == CODE_POS_FS),
         "flag");
      nst++;
      repeat (10) @(posedge clk);
   endtask : start
   task automatic t_stream();
      q = '{14'h2000, 14'h1fff, 14'h0000, 14'h3fff, 14'h0001, 14'h1ffe,
         14'h2001, 14'h0155, 14'h2aaa, 14'h0f0f};
      push();
      for (int i = 0; i < 10; i++) start(i == 4);
   endtask : t_stream
   task automatic t_fill();
      q = {};
      for (int i = 0; i < 16; i++) q.push_back(14'(i * 'h0123));
      push();
      @(negedge clk);
      chk(core_ready === 1'b0, "fifo not full");
      @(posedge clk);
      for (int i = 0; i < 16; i++) start(1'b0);
   endtask : t_fill
   task automatic t_idle();
      repeat (60) @(posedge clk);
      chk(refresh_active === 1'b1, "no refresh");
      pulse();
      repeat (6) @(posedge clk);
      chk(busy === 1'b0 && refresh_active === 1'b0, "empty start");
   endtask : t_idle
   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(core_ready === 1'b1 && busy === 1'b0 && data_out === DATA_RST,
         "reset state");
      t_stream();
      t_fill();
      t_idle();
      give_verdict();
   end
endmodule : testbench
